// ### hdl/ssp_unit.sv
// ssp_unit: lane-wise vector shift and carry-less multiply unit behind an ahb-lite slave
// Behaviour
// - shifted-out bits dropped, never cross lanes
// - amount from immediate or shift vector
// - vector amounts are signed per lane
// - signed right shift fills sign, unsigned zeros
// - left insert keeps destination low bits
// - right shift accumulate, plain and rounding
// - six modifiers (rnd, satS, satU, acc, insL, insR) adjust inputs or outputs only
// - unsigned saturation clamps to unsigned range
// - saturating right shifts only in narrow form
// - narrow takes quadword, gives half-width doubleword
// - byte and halfword polynomial lane types
// - each poly lane independent, byte and halfword widths only; word lanes multiply as integers
// - polynomial add is bitwise xor
// - polynomial multiply xors the partial products
// - only the two multiplies honour poly type
// - lane add always carries; xor for poly
`timescale 1ns/1ps
module ssp_unit import ssp_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);
	logic [3:0][31:0] opA, opB, dst, res;
	logic [3:0][31:0] next_opA, next_opB, next_dst, next_res;
	ssp_ctrl_s ctrl, next_ctrl;
	ssp_bus_s dph, next_dph;
	logic go, done, sat, next_go, next_done, next_sat;
	logic [31:0] next_rdata;
	logic [127:0] calc;
	logic satAny;

	// low w bits set
	function automatic logic [31:0] msk(input int w);
		logic [63:0] t;
		t = (64'h1 << w) - 64'h1;
		return t[31:0];
	endfunction : msk

	// extend a w-bit lane to the wide working width
	function automatic logic signed [79:0] ext(input logic [31:0] a, input int w, input logic sgn);
		logic signed [79:0] e;
		e = signed'(80'(a & msk(w)));
		if (sgn && a[w-1])
			e = e - (80'sd1 <<< w);
		return e;
	endfunction : ext

	function automatic logic isNarrow(input ssp_op_e op);
		return op inside {shift_right_narrow_op, saturating_shift_right_narrow_op,
			saturating_rounding_right_narrow_op, unsigned_sat_right_narrow_op,
			unsigned_sat_rounding_right_narrow_op};
	endfunction : isNarrow

	function automatic logic isLong(input ssp_op_e op);
		return op inside {shift_left_widen_op, widening_multiply_op};
	endfunction : isLong

	// one lane: a and b are sw wide, d and the result dw wide; bit 32 flags saturation
	function automatic logic [32:0] sspLane(input logic [31:0] a, input logic [31:0] b,
			input logic [31:0] d, input int sw, input int dw, input ssp_ctrl_s c);
		logic signed [79:0] e, eb, v, lo, hi;
		logic [31:0] r, hm;
		logic rgt, rnd, satS, satU, acc, insL, insR, sgn, s;
		int amt, n;
		rgt = 1'b0;
		rnd = 1'b0;
		satS = 1'b0;
		satU = 1'b0;
		acc = 1'b0;
		insL = 1'b0;
		insR = 1'b0;
		s = 1'b0;
		// modifiers only steer the input/output handling around one shifter
		unique case (c.op)
			shift_right_op, shift_right_narrow_op: rgt = 1'b1;
			shift_right_accumulate_op: {rgt, acc} = 2'b11;
			rounding_shift_right_accumulate_op: {rgt, acc, rnd} = 3'b111;
			rounding_shift_left_by_vector_op: rnd = 1'b1;
			saturating_shift_left_op: satS = 1'b1;
			saturating_rounding_shift_left_op: {satS, rnd} = 2'b11;
			saturating_shift_right_narrow_op: {rgt, satS} = 2'b11;
			saturating_rounding_right_narrow_op: {rgt, satS, rnd} = 3'b111;
			unsigned_sat_shift_left_op: satU = 1'b1;
			unsigned_sat_right_narrow_op: {rgt, satU} = 2'b11;
			unsigned_sat_rounding_right_narrow_op: {rgt, satU, rnd} = 3'b111;
			shift_left_insert_op: insL = 1'b1;
			shift_right_insert_op: {rgt, insR} = 2'b11;
			default: ;
		endcase
		// poly type must not change how shifts treat the sign
		sgn = c.isSigned && !insL && !insR;
		e = ext(a, sw, sgn);
		eb = ext(b, sw, sgn);
		// amount: immediate, or signed low byte of the matching shift lane
		if (rgt)
			amt = -int'(c.imm);
		else if (c.useReg)
			amt = int'(signed'(b[7:0]));
		else
			amt = int'(c.imm);
		if (amt > AMT_CLAMP)
			amt = AMT_CLAMP;
		if (amt < -AMT_CLAMP)
			amt = -AMT_CLAMP;
		n = -amt;
		if (c.op == lane_add_op)
			v = e + eb;
		else if (c.op == lane_xor_op)
			v = signed'(80'((a ^ b) & msk(sw)));
		else if (c.op inside {lane_multiply_op, widening_multiply_op}) begin
			if (c.poly && sw <= POLY_MAX) begin
				v = '0;
				for (int j = 0; j < POLY_MAX; j++)
					if (j < sw && b[j])
						v = v ^ signed'(80'(a & msk(sw)) << j);
			end else
				v = e * eb;
		end else if (amt >= 0)
			v = e <<< amt;
		else
			v = (rnd ? e + (80'sd1 <<< (n - 1)) : e) >>> n;
		// clamp to the result lane range
		hi = satU ? (80'sd1 <<< dw) - 80'sd1 : (80'sd1 <<< (dw - 1)) - 80'sd1;
		lo = satU ? 80'sd0 : -(80'sd1 <<< (dw - 1));
		if ((satS || satU) && v > hi) begin
			v = hi;
			s = 1'b1;
		end
		if ((satS || satU) && v < lo) begin
			v = lo;
			s = 1'b1;
		end
		r = v[31:0] & msk(dw);
		if (acc)
			r = (r + d) & msk(dw);
		if (insL)
			r = (r & ~msk(amt)) | (d & msk(amt));
		hm = msk(dw) & ~(msk(dw) >> n);
		if (insR)
			r = (r & ~hm) | (d & hm);
		return {s, r};
	endfunction : sspLane

	// all lanes of the vector, widths set by the size field and the op shape
	always_comb begin
		int el, sw, dw, lanes;
		logic [32:0] lr;
		el = 8 << ctrl.size;
		sw = el;
		dw = el;
		lanes = 0;
		lr = '0;
		calc = '0;
		satAny = 1'b0;
		if (isNarrow(ctrl.op))
			sw = 2 * el;
		if (isLong(ctrl.op))
			dw = 2 * el;
		if (sw <= LANE_MAX && dw <= LANE_MAX)
			lanes = VEC_W / (sw > dw ? sw : dw);
		for (int i = 0; i < VEC_W / 8; i++) begin
			if (i < lanes) begin
				lr = sspLane(32'(opA >> (i * sw)), 32'(opB >> (i * sw)), 32'(dst >> (i * dw)), sw, dw, ctrl);
				calc = calc | (128'(lr[31:0]) << (i * dw));
				satAny = satAny | lr[32];
			end
		end
	end

	// register file, launch, status and read data
	always_comb begin
		next_opA = opA;
		next_opB = opB;
		next_dst = dst;
		next_res = res;
		next_ctrl = ctrl;
		next_go = 1'b0;
		next_done = done;
		next_sat = sat;
		next_rdata = hrdata;
		// result lands one cycle after the control write
		if (go) begin
			next_res = calc;
			next_done = 1'b1;
			next_sat = satAny;
		end
		if (dph.valid && dph.write) begin
			unique case (dph.addr[7:4])
				ADDR_OPA[7:4]: next_opA[dph.addr[3:2]] = hwdata;
				ADDR_OPB[7:4]: next_opB[dph.addr[3:2]] = hwdata;
				ADDR_DST[7:4]: next_dst[dph.addr[3:2]] = hwdata;
				default: ;
			endcase
			if (dph.addr == ADDR_CTRL) begin
				next_ctrl = ssp_ctrl_s'(hwdata);
				next_go = 1'b1;
				next_done = 1'b0;
			end
		end
		next_dph.addr = haddr[7:0];
		next_dph.write = hwrite;
		next_dph.valid = hsel && hready && htrans[1];
		// read data taken from the updated values so a write just before is seen
		if (next_dph.valid && !hwrite) begin
			unique case (haddr[7:4])
				ADDR_OPA[7:4]: next_rdata = next_opA[haddr[3:2]];
				ADDR_OPB[7:4]: next_rdata = next_opB[haddr[3:2]];
				ADDR_DST[7:4]: next_rdata = next_dst[haddr[3:2]];
				ADDR_RES[7:4]: next_rdata = next_res[haddr[3:2]];
				default: next_rdata = 32'h0000_0000;
			endcase
			if (haddr[7:0] == ADDR_CTRL)
				next_rdata = 32'(next_ctrl);
			if (haddr[7:0] == ADDR_STAT) begin
				next_rdata = 32'h0000_0000;
				next_rdata[STAT_DONE_BIT] = next_done;
				next_rdata[STAT_SAT_BIT] = next_sat;
			end
			if (haddr[3:0] != 4'h0 && haddr[7:4] inside {ADDR_CTRL[7:4], ADDR_STAT[7:4]})
				next_rdata = 32'h0000_0000;
		end
	end

	// state registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			opA <= VEC_RESET;
			opB <= VEC_RESET;
			dst <= VEC_RESET;
			res <= VEC_RESET;
			ctrl <= ssp_ctrl_s'(CTRL_RESET);
			dph <= '0;
			go <= 1'b0;
			done <= 1'b0;
			sat <= 1'b0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			opA <= next_opA;
			opB <= next_opB;
			dst <= next_dst;
			res <= next_res;
			ctrl <= next_ctrl;
			dph <= next_dph;
			go <= next_go;
			done <= next_done;
			sat <= next_sat;
			hrdata <= next_rdata;
			hreadyout <= 1'b1; // zero wait states
			hresp <= 1'b0; // always okay
		end
	end
endmodule : ssp_unit

// ### hdl/ssp_pkg.sv
// ssp_pkg: constants and types of the simd shift and polynomial unit
package ssp_pkg;
	// register byte offsets; vector registers take four words, low word first
	localparam logic [7:0] ADDR_OPA = 8'h00;
	localparam logic [7:0] ADDR_OPB = 8'h10;
	localparam logic [7:0] ADDR_DST = 8'h20;
	localparam logic [7:0] ADDR_CTRL = 8'h30;
	localparam logic [7:0] ADDR_RES = 8'h40;
	localparam logic [7:0] ADDR_STAT = 8'h50;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [127:0] VEC_RESET = 128'h0;
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_SAT_BIT = 1;
	localparam int VEC_W = 128;
	localparam int LANE_MAX = 32;
	localparam int AMT_CLAMP = 40;
	localparam int POLY_MAX = 16;

	typedef enum logic [4:0] {
		shift_left_op = 5'h00,
		shift_left_widen_op = 5'h01,
		rounding_shift_left_by_vector_op = 5'h02,
		shift_right_op = 5'h03,
		shift_right_narrow_op = 5'h04,
		shift_right_accumulate_op = 5'h05,
		rounding_shift_right_accumulate_op = 5'h06,
		shift_left_insert_op = 5'h07,
		shift_right_insert_op = 5'h08,
		saturating_shift_left_op = 5'h09,
		saturating_rounding_shift_left_op = 5'h0a,
		saturating_shift_right_narrow_op = 5'h0b,
		saturating_rounding_right_narrow_op = 5'h0c,
		unsigned_sat_shift_left_op = 5'h0d,
		unsigned_sat_right_narrow_op = 5'h0e,
		unsigned_sat_rounding_right_narrow_op = 5'h0f,
		lane_multiply_op = 5'h10,
		widening_multiply_op = 5'h11,
		lane_add_op = 5'h12,
		lane_xor_op = 5'h13
	} ssp_op_e;

	// control word: op in bits 4:0, size 6:5, signed 7, poly 8, register amount 9, immediate 15:10
	typedef struct packed {
		logic [15:0] rsvd;
		logic [5:0] imm;
		logic useReg;
		logic poly;
		logic isSigned;
		logic [1:0] size;
		ssp_op_e op;
	} ssp_ctrl_s;

	// captured address phase
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic valid;
	} ssp_bus_s;
endpackage : ssp_pkg

// ### test/ssp_unit_monitor.sv
// ssp_unit_monitor: bus-side assertions on the shift and polynomial unit
`timescale 1ns/1ps
module ssp_unit_monitor import ssp_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// address phases taken by the slave
	sequence s_rd(a);
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
	endsequence
	sequence s_wr(a);
		hsel && hready && htrans[1] && hwrite && haddr[7:0] == a;
	endsequence
	// ready, response and read data behaviour
	property p_ready; $past(reset_n) |-> hreadyout; endproperty
	property p_okay; !hresp; endproperty
	property p_keep; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
	property p_empty; s_rd(8'h60) |=> hrdata == 32'h0; endproperty
	property p_stat; s_rd(ADDR_STAT) |=> hrdata[31:2] == 30'h0; endproperty
	property p_done; s_wr(ADDR_CTRL) ##2 s_rd(ADDR_STAT) |=> hrdata[STAT_DONE_BIT]; endproperty
	property p_clear; $rose(reset_n) |-> hrdata == 32'h0; endproperty
	property p_steady; !$fell(hreadyout); endproperty
	a_ready: assert property (p_ready) else $error("hreadyout low after reset");
	a_okay: assert property (p_okay) else $error("error response seen");
	a_keep: assert property (p_keep) else $error("read data changed without a read");
	a_empty: assert property (p_empty) else $error("unmapped read not zero");
	a_stat: assert property (p_stat) else $error("status spare bits set");
	a_done: assert property (p_done) else $error("done flag not set after operation");
	a_clear: assert property (p_clear) else $error("read data not cleared by reset");
	a_steady: assert property (p_steady) else $error("hreadyout dropped");
endmodule : ssp_unit_monitor

bind ssp_unit ssp_unit_monitor i_ssp_unit_monitor (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp);

// ### test/ssp_host_model.sv
// ssp_host_model: ahb-lite master standing in for the processor side
`timescale 1ns/1ps
module ssp_host_model (
	input wire logic clk_sys,
	input wire logic hready,
	output logic hsel = 1'b0,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'h0,
	output logic hwrite = 1'b0,
	output logic [2:0] hsize = 3'h2,
	output logic [31:0] hwdata = 32'h0
);
	// address phase held until ready, then data phase held until ready
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
	endtask : xfer
endmodule : ssp_host_model

// ### test/ssp_unit_tb.sv
// ssp_unit_tb: register-level tests of the shift and polynomial unit
`timescale 1ns/1ps
module ssp_unit_tb import ssp_pkg::*;;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int error_cnt = 0;
	int checks = 0;

	// 40 mhz clock
	initial forever #12.5 clk_sys = ~clk_sys;

	ssp_host_model i_ssp_host_model (.clk_sys, .hready(hreadyout), .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata);
	ssp_unit i_ssp_unit (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp);

	// verdict and end of run
	task results;
		if (error_cnt == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results

	task automatic chk(logic [31:0] r, logic [31:0] e);
		checks++;
		if (r !== e) begin
			error_cnt++;
			$display("Error t=%0t got %h exp %h", $time, r, e);
		end
	endtask : chk

	task automatic x(logic w, logic [7:0] a, logic [31:0] d);
		i_ssp_host_model.xfer(w, {24'h0, a}, d);
	endtask : x

	// load operands, start the op, read status once, check result word 0
	task automatic t(ssp_op_e o, logic [10:0] m, logic [31:0] a, logic [31:0] b, logic [31:0] e, logic s = 1'b0);
		ssp_ctrl_s c;
		c = '{16'h0, m[10:5], m[4], m[3], m[2], m[1:0], o};
		x(1'b1, ADDR_OPA, a);
		x(1'b1, ADDR_OPB, b);
		x(1'b1, ADDR_DST, b);
		x(1'b1, ADDR_CTRL, c);
		x(1'b0, ADDR_STAT, 32'h0);
		chk(hrdata, (32'(s) << STAT_SAT_BIT) | (32'h0000_0001 << STAT_DONE_BIT));
		x(1'b0, ADDR_RES, 32'h0);
		chk(hrdata, e);
	endtask : t

	// watchdog
	initial begin
		#20us;
		error_cnt++;
		results();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t(shift_left_op, 11'h080, 32'h8143_21F0, 32'h0, 32'h1030_1000);
		t(shift_left_op, 11'h010, 32'h8080_8080, 32'h02FE_0000, 32'h0020_8080);
		t(shift_right_op, 11'h044, 32'h8040_FF7C, 32'h0, 32'hE010_FF1F);
		t(shift_right_op, 11'h04C, 32'h8040_FF7C, 32'h0, 32'hE010_FF1F);
		t(shift_left_insert_op, 11'h080, 32'h1234_5678, 32'hABCD_EF01, 32'h2B4D_6F81);
		t(shift_right_insert_op, 11'h080, 32'h1234_5678, 32'hABCD_EF01, 32'hA1C3_E507);
		t(shift_right_accumulate_op, 11'h020, 32'h0303_0303, 32'h1010_1010, 32'h1111_1111);
		t(rounding_shift_right_accumulate_op, 11'h020, 32'h0303_0303, 32'h1010_1010, 32'h1212_1212);
		t(saturating_shift_left_op, 11'h024, 32'h8040_017F, 32'h0, 32'h807F_027F, 1'b1);
		t(unsigned_sat_shift_left_op, 11'h024, 32'hFF40_0180, 32'h0, 32'h0080_0200, 1'b1);
		t(shift_right_narrow_op, 11'h080, 32'h1234_ABCD, 32'h0, 32'h0000_23BC);
		t(saturating_shift_right_narrow_op, 11'h084, 32'h1234_ABCD, 32'h0, 32'h0000_7F80, 1'b1);
		t(lane_multiply_op, 11'h008, 32'h0303_0303, 32'h0303_0303, 32'h0505_0505);
		t(lane_multiply_op, 11'h000, 32'h0303_0303, 32'h0303_0303, 32'h0909_0909);
		t(lane_multiply_op, 11'h009, 32'h0003_0003, 32'h0003_0003, 32'h0005_0005);
		t(widening_multiply_op, 11'h008, 32'h0000_0F03, 32'h0000_0F03, 32'h0055_0005);
		t(lane_add_op, 11'h008, 32'h0303_0303, 32'h0303_0303, 32'h0606_0606);
		t(lane_xor_op, 11'h000, 32'h0303_0303, 32'h0506_0303, 32'h0605_0000);
		x(1'b0, 8'h60, 32'h0);
		chk(hrdata, 32'h0);
		results();
	end
endmodule : ssp_unit_tb
